// *** logic/exec_consts.svh ***
// Constants for the move, multiply, negate and stack instruction group.
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define OPC_LIT_LOAD    8'h0E
`define OPC_LIT_MUL     8'h0D
`define OPC_BANK_LOAD   8'h01
`define OPC7_REG_MUL    7'h01
`define OPC7_NEGATE     7'h36
`define OPC6_COPY       6'h14
`define OPC4_FF_COPY    4'hC
`define OPC4_SECOND     4'hF
`define OPC_STACK_PUSH  16'h0005
`define OPC_STACK_POP   16'h0006
`define FLAG_C          0
`define FLAG_DC         1
`define FLAG_Z          2
`define FLAG_OV         3
`define FLAG_N          4
`define ACCESS_SPLIT    8'h60
`define ACCESS_HI_BANK  4'hF
`define PC_STEP         21'h000002
`endif

// *** logic/exec_pkg.sv ***
// Types for the instruction group executor.
package exec_pkg;
  typedef enum logic [1:0] {
    EX_FETCH  = 2'b00,
    EX_SECOND = 2'b01,
    EX_WRITE  = 2'b11
  } exec_state_t;
endpackage : exec_pkg

// *** logic/ret_stack_if.sv ***
// Interface between the executor and its return stack memory.
interface ret_stack_if;
  logic        push;
  logic        pop;
  logic [20:0] wdata;
  logic [20:0] top;
  modport exec  (output push, output pop, output wdata, input top);
  modport stack (input push, input pop, input wdata, output top);
endinterface : ret_stack_if

// *** logic/ret_stack_mem.sv ***
// Return stack memory with a registered top entry.
module ret_stack_mem #(
  parameter int DEPTH = 31
) (
  input  wire logic  core_clk,
  input  wire logic  rst_b,
  ret_stack_if.stack rs
);
  logic [20:0] mem_q [DEPTH];
  logic [20:0] top_q;
  logic [4:0]  ptr_q;
  assign rs.top = top_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      top_q <= 21'h000000;
      ptr_q <= 5'h00;
    end else if (rs.push) begin
      mem_q[ptr_q] <= top_q;
      top_q        <= rs.wdata;
      ptr_q        <= ptr_q + 5'h01;
    end else if (rs.pop) begin
      top_q <= (ptr_q == 5'h00) ? 21'h000000 : mem_q[ptr_q - 5'h01];
      ptr_q <= (ptr_q == 5'h00) ? 5'h00 : ptr_q - 5'h01;
    end
  end
endmodule : ret_stack_mem

// *** logic/instr_exec.sv ***
// Executor for the move, multiply, negate and return stack instructions.
`include "exec_consts.svh"
module instr_exec #(
  parameter int STACK_DEPTH = 31
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [20:0] pc,
  input  wire logic        write_stall,
  output logic             instr_ready,
  output logic [11:0]      mem_addr,
  output logic             mem_we,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  output logic [7:0]       acc,
  output logic [7:0]       product_high_byte,
  output logic [7:0]       product_low_byte,
  output logic [7:0]       bank_pointer,
  output logic [4:0]       status_flags,
  output logic [20:0]      return_stack_top
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  exec_pkg::exec_state_t state_q, state_d;
  logic [7:0]  copy_q;
  logic [7:0]  acc_q, prod_hi_q, prod_lo_q, bank_q, wdata_q;
  logic [4:0]  flags_q;
  logic [11:0] waddr_q;
  logic        we_q;
  ret_stack_if rs ();

  function automatic logic [11:0] reg_addr(input logic [15:0] w, input logic [7:0] bank);
    if (w[8])
      reg_addr = {bank[3:0], w[7:0]};
    else
      reg_addr = (w[7:0] < `ACCESS_SPLIT) ? {4'h0, w[7:0]} : {`ACCESS_HI_BANK, w[7:0]};
  endfunction : reg_addr

  wire logic        idle       = (state_q == exec_pkg::EX_FETCH);
  wire logic        take       = instr_valid && instr_ready;
  wire logic        is_lit     = take && idle && instr_word[15:8] == `OPC_LIT_LOAD;
  wire logic        is_lmul    = take && idle && instr_word[15:8] == `OPC_LIT_MUL;
  wire logic        is_bank    = take && idle && instr_word[15:8] == `OPC_BANK_LOAD;
  wire logic        is_rmul    = take && idle && instr_word[15:9] == `OPC7_REG_MUL;
  wire logic        is_neg     = take && idle && instr_word[15:9] == `OPC7_NEGATE;
  wire logic        is_copy    = take && idle && instr_word[15:10] == `OPC6_COPY;
  wire logic        is_ff      = take && idle && instr_word[15:12] == `OPC4_FF_COPY;
  wire logic        is_second  = take && state_q == exec_pkg::EX_SECOND;
  wire logic        is_push    = take && idle && instr_word == `OPC_STACK_PUSH;
  wire logic        is_pop     = take && idle && instr_word == `OPC_STACK_POP;
  // Both words of the two-word copy carry a full 12-bit address, so no banking applies to them.
  wire logic        abs_src    = is_ff || is_second;
  wire logic [11:0] op_addr    = reg_addr(instr_word, bank_q);
  wire logic [15:0] lit_prod   = acc_q * instr_word[7:0];
  wire logic [15:0] reg_prod   = acc_q * mem_rdata;
  wire logic [8:0]  neg_sum    = {1'b0, ~mem_rdata} + 9'h001;
  wire logic [4:0]  neg_low    = {1'b0, ~mem_rdata[3:0]} + 5'h01;
  wire logic [7:0]  neg_val    = neg_sum[7:0];

  assign instr_ready       = (state_q != exec_pkg::EX_WRITE);
  assign mem_addr          = we_q ? waddr_q : (abs_src ? instr_word[11:0] : op_addr);
  assign mem_we            = we_q;
  assign mem_wdata         = wdata_q;
  assign acc               = acc_q;
  assign product_high_byte = prod_hi_q;
  assign product_low_byte  = prod_lo_q;
  assign bank_pointer      = bank_q;
  assign status_flags      = flags_q;
  assign return_stack_top  = rs.top;
  assign rs.push           = is_push;
  assign rs.pop            = is_pop;
  assign rs.wdata          = pc + `PC_STEP;

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      exec_pkg::EX_FETCH:  state_d = is_ff ? exec_pkg::EX_SECOND : exec_pkg::EX_FETCH;
      exec_pkg::EX_SECOND: state_d = (is_second && write_stall) ? exec_pkg::EX_WRITE :
                                     (is_second ? exec_pkg::EX_FETCH : exec_pkg::EX_SECOND);
      exec_pkg::EX_WRITE:  state_d = exec_pkg::EX_FETCH;
      default:             state_d = exec_pkg::EX_FETCH;
    endcase
  end

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  wire logic        copy_to_acc = is_copy && !instr_word[9];
  wire logic        copy_to_reg = is_copy && instr_word[9];
  wire logic        reg_write   = is_neg || copy_to_reg;
  wire logic [7:0]  copy_d      = is_ff ? mem_rdata : copy_q;
  wire logic [7:0]  acc_d       = is_lit ? instr_word[7:0] :
                                  (copy_to_acc ? mem_rdata : acc_q);
  wire logic [15:0] prod_d      = is_lmul ? lit_prod :
                                  (is_rmul ? reg_prod : {prod_hi_q, prod_lo_q});
  wire logic [7:0]  bank_d      = is_bank ? {4'h0, instr_word[3:0]} : bank_q;
  wire logic        we_d        = is_second || reg_write;
  wire logic [11:0] waddr_d     = is_second ? instr_word[11:0] : (reg_write ? op_addr : waddr_q);
  wire logic [7:0]  wdata_d     = is_second ? copy_q :
                                  (is_neg ? neg_val : (copy_to_reg ? mem_rdata : wdata_q));
  logic [4:0] flags_d;

  // Multiplies never touch the flags, so a zero product goes unflagged.
  always_comb begin
    flags_d = flags_q;
    if (is_neg) begin
      flags_d[`FLAG_C]  = neg_sum[8];
      flags_d[`FLAG_DC] = neg_low[4];
      flags_d[`FLAG_Z]  = (neg_val == 8'h00);
      flags_d[`FLAG_OV] = (mem_rdata == 8'h80);
      flags_d[`FLAG_N]  = neg_val[7];
    end
    if (is_copy) begin
      flags_d[`FLAG_Z] = (mem_rdata == 8'h00);
      flags_d[`FLAG_N] = mem_rdata[7];
    end
  end

  // ----------------------------------------
  // Sequencing register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= exec_pkg::EX_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      copy_q <= 8'h00;
    end else begin
      copy_q <= copy_d;
    end
  end

  // ----------------------------------------
  // Results
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prod_hi_q <= 8'h00;
    end else begin
      prod_hi_q <= prod_d[15:8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prod_lo_q <= 8'h00;
    end else begin
      prod_lo_q <= prod_d[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_q <= 8'h00;
    end else begin
      bank_q <= bank_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= 5'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------
  // Write port
  // ----------------------------------------
  // The write lands one cycle late; an instruction offered in that cycle loses mem_addr to it.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      we_q    <= 1'b0;
      waddr_q <= 12'h000;
      wdata_q <= 8'h00;
    end else begin
      we_q    <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  ret_stack_mem #(.DEPTH(STACK_DEPTH)) u_stack (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .rs       (rs.stack)
  );
endmodule : instr_exec

// *** tb/exec_chk_sva.sv ***
// Assertion checker for the instruction group executor.
`include "exec_consts.svh"
// ----------------------------------------------------------
// Checker
// ----------------------------------------------------------
module exec_chk (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [20:0] pc,
  input wire logic        write_stall,
  input wire logic        instr_ready,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  product_high_byte,
  input wire logic [7:0]  product_low_byte,
  input wire logic [7:0]  bank_pointer,
  input wire logic [4:0]  status_flags,
  input wire logic [20:0] return_stack_top
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic tk = instr_valid && instr_ready;
  wire logic [15:0] prod = {product_high_byte, product_low_byte};
  property p_lit; tk && instr_word[15:8] == `OPC_LIT_LOAD |=> acc == $past(instr_word[7:0]) && $stable(status_flags); endproperty
  a_lit: assert property (p_lit) else $error("literal load wrong");
  property p_lmul; tk && instr_word[15:8] == `OPC_LIT_MUL |=> prod == $past(acc) * $past(instr_word[7:0]) && $stable(acc) && $stable(status_flags); endproperty
  a_lmul: assert property (p_lmul) else $error("literal multiply wrong");
  property p_rmul; tk && instr_word[15:9] == `OPC7_REG_MUL |=> prod == $past(acc) * $past(mem_rdata) && !mem_we && $stable(status_flags); endproperty
  a_rmul: assert property (p_rmul) else $error("register multiply wrong");
  property p_neg; tk && instr_word[15:9] == `OPC7_NEGATE |=> mem_we && mem_wdata == 8'h00 - $past(mem_rdata) && mem_addr == $past(mem_addr) && status_flags[`FLAG_N] == mem_wdata[7]; endproperty
  a_neg: assert property (p_neg) else $error("negate wrong");
  property p_copy; tk && instr_word[15:12] == `OPC4_FF_COPY ##1 tk && !write_stall |=> mem_we && mem_addr == $past(instr_word[11:0]) && mem_wdata == $past(mem_rdata, 2); endproperty
  a_copy: assert property (p_copy) else $error("file copy wrong");
  property p_stall; tk && instr_word[15:12] == `OPC4_SECOND && write_stall |=> !instr_ready ##1 instr_ready; endproperty
  a_stall: assert property (p_stall) else $error("stalled copy length wrong");
  property p_push; tk && instr_word == `OPC_STACK_PUSH |=> return_stack_top == $past(pc) + 21'h000002; endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop; tk && instr_word == `OPC_STACK_PUSH ##1 tk && instr_word == `OPC_STACK_POP |=> return_stack_top == $past(return_stack_top, 2); endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_addr; tk && instr_word[15:10] == `OPC6_COPY && !mem_we |-> mem_addr == (instr_word[8] ? {bank_pointer[3:0], instr_word[7:0]} : {((instr_word[7:0] < `ACCESS_SPLIT) ? 4'h0 : 4'hF), instr_word[7:0]}); endproperty
  a_addr: assert property (p_addr) else $error("bank selection wrong");
  property p_dst; tk && instr_word[15:10] == `OPC6_COPY && !mem_we |=> ($past(instr_word[9]) ? mem_we : acc == $past(mem_rdata)); endproperty
  a_dst: assert property (p_dst) else $error("destination select wrong");
  property p_bank; tk && instr_word[15:8] == `OPC_BANK_LOAD |=> bank_pointer == {4'h0, $past(instr_word[3:0])} && $stable(status_flags); endproperty
  a_bank: assert property (p_bank) else $error("bank load wrong");
  c_stall: cover property (tk && instr_word[15:12] == `OPC4_SECOND && write_stall);
  c_neg: cover property (tk && instr_word[15:9] == `OPC7_NEGATE);
  c_pop: cover property (tk && instr_word == `OPC_STACK_POP);
endmodule : exec_chk
bind instr_exec exec_chk u_chk (.*);

// *** tb/tb.sv ***
// Self-checking testbench for the instruction group executor.
`include "exec_consts.svh"
// ----------------------------------------------------------
// Bench
// ----------------------------------------------------------
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst_b = 1'b0, instr_valid = 1'b0, write_stall = 1'b0, mid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [20:0] pc = 21'h000000, p, return_stack_top;
  logic        instr_ready, mem_we;
  logic [11:0] mem_addr, s, d;
  logic [7:0]  mem_wdata, mem_rdata, acc, product_high_byte, product_low_byte, bank_pointer, a, b, c, x;
  logic [4:0]  status_flags;
  logic [7:0]  mem [0:4095];
  int          err_count = 0, checks = 0, seed = 13;
  always #25 core_clk = ~core_clk;
  assign mem_rdata = mem[mem_addr];
  always @(posedge core_clk) if (mem_we) mem[mem_addr] <= mem_wdata;
  instr_exec u_dut (.*);
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Sampling ready at the falling edge keeps the take decision clear of the edge that updates it.
  task automatic issue(input logic [15:0] w);
    bit t;
    t = 1'b0;
    if (mid) @(posedge core_clk);
    mid = 1'b0;
    instr_valid <= 1'b1;
    instr_word  <= w;
    for (int n = 0; n < 8 && !t; n++) begin
      @(negedge core_clk);
      t = (instr_ready === 1'b1);
      @(posedge core_clk);
    end
    if (!t) begin
      chk(1'b0, "no take");
      finish_test();
    end
  endtask : issue
  task automatic settle;
    instr_valid <= 1'b0;
    write_stall <= 1'b0;
    repeat (4) @(negedge core_clk);
    mid = 1'b1;
  endtask : settle
  function automatic logic [4:0] nflags(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00 - v;
    nflags = 5'h00;
    nflags[`FLAG_N] = r[7];
    nflags[`FLAG_Z] = (r == 8'h00);
    nflags[`FLAG_C] = (v == 8'h00);
    nflags[`FLAG_DC] = (v[3:0] == 4'h0);
    nflags[`FLAG_OV] = (v == 8'h80);
  endfunction : nflags
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = $random(seed);
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      a = (i == 0) ? 8'hFF : $random(seed);
      b = (i == 0) ? 8'hFF : $random(seed);
      c = $random(seed);
      issue({`OPC_LIT_LOAD, a});
      issue({`OPC_LIT_MUL, b});
      issue({`OPC_BANK_LOAD, b});
      settle();
      chk(acc === a, "acc");
      chk({product_high_byte, product_low_byte} === a * b, "lit product");
      chk(bank_pointer === {4'h0, b[3:0]}, "bank");
      issue({`OPC7_REG_MUL, 1'b1, c});
      settle();
      chk({product_high_byte, product_low_byte} === a * mem[{b[3:0], c}], "reg product");
      // Zero and the most negative value are the two inputs whose negation is its own edge case.
      if (i < 2) mem[{b[3:0], c}] = i[0] ? 8'h80 : 8'h00;
      x = mem[{b[3:0], c}];
      issue({`OPC7_NEGATE, 1'b1, c});
      settle();
      chk(mem[{b[3:0], c}] === 8'h00 - x, "negate value");
      chk(status_flags === nflags(x), "negate flags");
      issue({`OPC6_COPY, i[0], 1'b1, c});
      settle();
      chk(acc === (i[0] ? a : mem[{b[3:0], c}]), "copy dest");
      s = $random(seed);
      d = s ^ 12'h801;
      x = mem[s];
      issue({`OPC4_FF_COPY, s});
      write_stall <= i[0];
      issue({`OPC4_SECOND, d});
      settle();
      chk(mem[d] === x, "file copy");
      p = $random(seed);
      pc <= p;
      issue(`OPC_STACK_PUSH);
      pc <= ~p;
      issue(`OPC_STACK_PUSH);
      settle();
      chk(return_stack_top === ~p + 21'h000002, "push");
      issue(`OPC_STACK_PUSH);
      issue(`OPC_STACK_POP);
      settle();
      chk(return_stack_top === ~p + 21'h000002, "push then pop");
      issue(`OPC_STACK_POP);
      settle();
      chk(return_stack_top === p + 21'h000002, "pop");
      issue(`OPC_STACK_POP);
      settle();
    end
    finish_test();
  end
endmodule : tb
